// *** logic/lvd_pkg.sv ***
package lvd_pkg;

  // register map (byte addresses on a 32-bit wishbone bus)
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] SUPPLY_MONITOR_CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS          = 4'h4;

  // supply_monitor_ctrl field positions
  localparam int unsigned FLAG_BIT   = 5;
  localparam int unsigned ON_BIT     = 4;
  localparam int unsigned THR_LSB    = 0;
  localparam int unsigned THR_W      = 3;

  // irq status register field positions
  localparam int unsigned IRQ_REQ_BIT    = 0;
  localparam int unsigned SHARED_REQ_BIT = 1;

  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

  // timing in ns at 50 MHz
  localparam int unsigned CLK_PERIOD_NS       = 20;
  localparam int unsigned IRQ_ASSERT_DELAY_NS = 1000;
  localparam int unsigned IRQ_ASSERT_DELAY_CYC =
    (IRQ_ASSERT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // threshold codes, named in volts for reference
  typedef enum logic [2:0] {
    THR_1V8 = 3'h0,
    THR_2V0 = 3'h1,
    THR_2V4 = 3'h2,
    THR_2V7 = 3'h3,
    THR_3V0 = 3'h4,
    THR_3V3 = 3'h5,
    THR_3V6 = 3'h6,
    THR_4V0 = 3'h7
  } lvd_thr_type;

  typedef struct packed {
    logic        monitor_on;
    lvd_thr_type threshold_select;
  } lvd_ctrl_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_DELAY = 2'h1,
    ST_HELD  = 2'h2
  } lvd_state_type;

  // threshold code to millivolts
  function automatic logic [11:0] lvd_thr_mv(input lvd_thr_type code);
    case (code)
      THR_1V8: lvd_thr_mv = 12'h708;
      THR_2V0: lvd_thr_mv = 12'h7D0;
      THR_2V4: lvd_thr_mv = 12'h960;
      THR_2V7: lvd_thr_mv = 12'hA8C;
      THR_3V0: lvd_thr_mv = 12'hBB8;
      THR_3V3: lvd_thr_mv = 12'hCE4;
      THR_3V6: lvd_thr_mv = 12'hE10;
      default: lvd_thr_mv = 12'hFA0;
    endcase
  endfunction

endpackage

// *** logic/lvd_sync.sv ***
`timescale 1ns/1ns
module lvd_sync
  #(parameter int unsigned WIDTH = 1)
  (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // async in, synchronous out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
  );

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

// *** logic/lvd_ctrl.sv ***
`timescale 1ns/1ns
// Summary of operation
// [R1] The control word holds the read-only flag at bit 5, enable at bit 4, threshold at bits 2..0, all zero at reset.
// [R2] Threshold codes 000..111 select 1.8, 2.0, 2.4, 2.7, 3.0, 3.3, 3.6 and 4.0 volts.
// [R3] The flag reads one while the supply is below the selected level and zero when above.
// [R4] Setting enable turns the detector on and clearing it switches the detector off.
// [R5] In sleep the detector is off whatever the enable bit says.
// [R6] Software should wait a settle time after enabling and tolerate flag chatter near the level.
// [R7] The interrupt request rises only after a fixed delay from the flag going high; here a software write of one to the status request bit also sets it at once.
// [R8] The request feeds the shared interrupt; software may use it or poll the flag.
// [R9] A rising request wakes the device from idle; setting the request beforehand masks the wake.
// [R10] Bits 7, 6 and 3 of the control word always read zero.
// [R11] A wake pulse is made on every low-to-high change of the request, enabled or not.
// [R12] Servicing clears only the shared request; software clears the individual request itself.
// [R13] The comparator output is synchronised before use and writes to the flag bit are ignored.
module lvd_ctrl
  import lvd_pkg::*;
  #(parameter int unsigned DELAY_CYC = IRQ_ASSERT_DELAY_CYC)
  (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone classic slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // analogue comparator side
  input  wire logic              comp_below_i,
  output logic                   comp_enable_o,
  output logic      [THR_W-1:0]  comp_threshold_o,
  output logic      [11:0]       comp_threshold_mv_o,
  // power mode and interrupt controller
  input  wire logic              sleep_i,
  input  wire logic              shared_irq_service_i,
  output logic                   undervoltage_irq_request_o,
  output logic                   shared_irq_request_o,
  output logic                   wake_o
  );

  lvd_ctrl_type  ctrl_ff;
  lvd_state_type state_ff;
  lvd_state_type nxt_state;
  logic [15:0]   delay_cnt_ff;
  logic          below_sync;
  logic          flag;
  logic          irq_req_ff;
  logic          irq_req_prev_ff;
  logic          shared_req_ff;
  logic          wake_ff;
  logic          ack_ff;
  logic [31:0]   dat_ff;
  logic          req;
  logic          wr_ctrl;
  logic          wr_stat;
  logic          delay_done;
  logic          irq_set;

  lvd_sync #(.WIDTH(1)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (comp_below_i),
    .sync_o  (below_sync)
  ); // R13

  // single-cycle answer, ack drops the cycle after it was given
  assign req     = cyc_i && stb_i && !ack_ff;
  assign wr_ctrl = req && we_i && sel_i[0] && (adr_i == SUPPLY_MONITOR_CTRL_OFS);
  assign wr_stat = req && we_i && sel_i[0] && (adr_i == IRQ_STATUS_OFS);

  // detector powered only when enabled and not asleep
  assign comp_enable_o       = ctrl_ff.monitor_on && !sleep_i; // R4 R5
  assign comp_threshold_o    = ctrl_ff.threshold_select; // R2
  assign comp_threshold_mv_o = lvd_thr_mv(ctrl_ff.threshold_select); // R2
  // a disabled comparator output is meaningless, so the flag is forced low
  assign flag = below_sync && comp_enable_o; // R3 R5

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff.monitor_on       <= CTRL_RESET[ON_BIT]; // R1
      ctrl_ff.threshold_select <= lvd_thr_type'(CTRL_RESET[THR_LSB +: THR_W]); // R1
    end else if (wr_ctrl) begin
      // flag bit not writable
      ctrl_ff.monitor_on       <= dat_i[ON_BIT]; // R4 R13
      ctrl_ff.threshold_select <= lvd_thr_type'(dat_i[THR_LSB +: THR_W]); // R1
    end
  end

  assign delay_done = (delay_cnt_ff == 16'(DELAY_CYC - 1));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (flag) nxt_state = ST_DELAY;
      ST_DELAY: begin
        if (!flag) begin
          nxt_state = ST_IDLE;
        end else if (delay_done) begin
          nxt_state = ST_HELD;
        end
      end
      ST_HELD:  if (!flag) nxt_state = ST_IDLE;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // flag must stay high for the whole delay before the request is raised
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_cnt_ff <= 16'h0000;
    end else if (state_ff == ST_DELAY && flag) begin
      delay_cnt_ff <= delay_cnt_ff + 16'h0001; // R7
    end else begin
      delay_cnt_ff <= 16'h0000;
    end
  end

  assign irq_set = (state_ff == ST_DELAY) && flag && delay_done; // R7

  // sticky request; hardware set wins over software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_ff <= 1'b0;
    end else if (irq_set) begin
      irq_req_ff <= 1'b1; // R7
    end else if (wr_stat) begin
      irq_req_ff <= dat_i[IRQ_REQ_BIT]; // R9 R12
    end
  end

  // shared request: set on any individual rise, cleared by service
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_req_ff <= 1'b0;
    end else if (irq_req_ff && !irq_req_prev_ff) begin
      shared_req_ff <= 1'b1; // R8
    end else if (shared_irq_service_i) begin
      shared_req_ff <= 1'b0; // R12
    end else if (wr_stat) begin
      shared_req_ff <= dat_i[SHARED_REQ_BIT];
    end
  end

  // wake pulse on low-to-high of the request, no enable involved
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_prev_ff <= 1'b0;
      wake_ff         <= 1'b0;
    end else begin
      irq_req_prev_ff <= irq_req_ff;
      wake_ff         <= irq_req_ff && !irq_req_prev_ff; // R9 R11
    end
  end

  assign undervoltage_irq_request_o = irq_req_ff; // R8
  assign shared_irq_request_o       = shared_req_ff; // R8
  assign wake_o                     = wake_ff;

  // read mux; unimplemented bits and unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= READ_ZERO;
    end else begin
      ack_ff <= req;
      dat_ff <= READ_ZERO;
      if (req && !we_i) begin
        case (adr_i)
          SUPPLY_MONITOR_CTRL_OFS: begin
            dat_ff[FLAG_BIT]               <= flag; // R3 R10
            dat_ff[ON_BIT]                 <= ctrl_ff.monitor_on;
            dat_ff[THR_LSB +: THR_W]       <= ctrl_ff.threshold_select;
          end
          IRQ_STATUS_OFS: begin
            dat_ff[IRQ_REQ_BIT]    <= irq_req_ff;
            dat_ff[SHARED_REQ_BIT] <= shared_req_ff;
          end
          default: dat_ff <= READ_ZERO;
        endcase
      end
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = dat_ff;

endmodule

// *** tb/lvd_ctrl_assertions.sv ***
`timescale 1ns/1ns
module lvd_chk
  import lvd_pkg::*;
  #(parameter int unsigned DELAY_CYC = 4)
  (
  // watched ports
  input wire logic              clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, sleep_i,
  input wire logic              comp_below_i, comp_enable_o, wake_o,
  input wire logic              undervoltage_irq_request_o, shared_irq_request_o,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [31:0]       dat_o,
  input wire logic [THR_W-1:0]  comp_threshold_o,
  input wire logic [11:0]       comp_threshold_mv_o
  );
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  localparam logic [11:0] MV [8] = '{12'h708, 12'h7D0, 12'h960, 12'hA8C,
                                     12'hBB8, 12'hCE4, 12'hE10, 12'hFA0};
  int unsigned low_cnt_ff;
  always_ff @(posedge clk_i)
    low_cnt_ff <= (rst_i || !comp_below_i || !comp_enable_o) ? 0 : low_cnt_ff + 1;
  // a software write also sets the request, so only hardware rises count here
  sequence hw_req_rise;
    $rose(undervoltage_irq_request_o) && !ack_o;
  endsequence
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  chk_sleep_off: assert property (sleep_i |-> !comp_enable_o) else $error("on in sleep");
  chk_thr_level: assert property (comp_threshold_mv_o == MV[comp_threshold_o])
    else $error("level wrong");
  chk_req_delay: assert property (hw_req_rise |-> low_cnt_ff >= DELAY_CYC)
    else $error("request early");
  chk_wake_rise: assert property ($rose(undervoltage_irq_request_o) |=> wake_o)
    else $error("no wake");
  chk_wake_pulse: assert property (wake_o |=> !wake_o) else $error("wake long");
  chk_shared_set: assert property (hw_req_rise |=> shared_irq_request_o)
    else $error("shared not set");
  chk_unimpl_zero: assert property (ack_o && !we_i && adr_i == SUPPLY_MONITOR_CTRL_OFS
    |-> dat_o[31:8] == 24'h0 && dat_o[7:6] == 2'h0 && !dat_o[3]) else $error("bits set");
endmodule
bind lvd_ctrl lvd_chk #(.DELAY_CYC(DELAY_CYC)) u_chk (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .ack_o, .sleep_i, .comp_below_i, .comp_enable_o, .wake_o,
  .undervoltage_irq_request_o, .shared_irq_request_o, .adr_i, .dat_o,
  .comp_threshold_o, .comp_threshold_mv_o);

// *** tb/lvd_comp_model.sv ***
`timescale 1ns/1ns
module lvd_comp_model
  (
  input wire logic        clk_i, enable_i,
  input wire logic [11:0] level_mv_i, supply_mv_i,
  output logic            below_o = 1'b0
  );
  // a switched-off comparator says nothing useful, so let it chatter
  always_ff @(posedge clk_i)
    below_o <= enable_i ? (supply_mv_i < level_mv_i) : !below_o;
endmodule

// *** tb/lvd_ctrl_test.sv ***
`timescale 1ns/1ns
module lvd_ctrl_test;
  import lvd_pkg::*;
  localparam int unsigned DLY = 4;
  localparam logic [11:0] MV [8] = '{12'h708, 12'h7D0, 12'h960, 12'hA8C,
                                     12'hBB8, 12'hCE4, 12'hE10, 12'hFA0};
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sleep = 0, svc = 0;
  logic        below, ack, en, ireq, sreq, wake;
  logic [3:0]  adr = 0, sel = 4'h1;
  logic [31:0] wdat = 0, rdat;
  logic [2:0]  thr;
  logic [11:0] mv, supply = 12'hFFF;
  logic [7:0]  expq[$];
  int          error_cnt = 0, comparisons = 0, wakes = 0;
  always #10 clk_i = ~clk_i;
  lvd_ctrl #(.DELAY_CYC(DLY)) u_dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .comp_below_i(below),
    .comp_enable_o(en), .comp_threshold_o(thr), .comp_threshold_mv_o(mv), .sleep_i(sleep),
    .shared_irq_service_i(svc), .undervoltage_irq_request_o(ireq),
    .shared_irq_request_o(sreq), .wake_o(wake));
  lvd_comp_model u_comp (.clk_i, .enable_i(en), .level_mv_i(mv), .supply_mv_i(supply),
    .below_o(below));
  task automatic results();
    if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
    if (n == 20) begin error_cnt++; results(); end
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expq.push_back(e);
    bus(0, a, 8'h00);
  endtask
  task automatic pulse_svc();
    svc <= 1;
    @(posedge clk_i);
    svc <= 0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (wake === 1'b1) wakes++;
    if (ack === 1'b1 && !we) chk("read", {4'h0, expq.pop_front()}, {4'h0, rdat[7:0]});
  end
  initial begin
    int n;
    int w0;
    logic [7:0] c;
    void'($urandom(32'h40717849));
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(SUPPLY_MONITOR_CTRL_OFS, 8'h00);
    rd(IRQ_STATUS_OFS, 8'h00);
    rd(4'hC, 8'h00);
    for (int i = 0; i < 8; i++) begin
      c = 8'($urandom_range(0, 1));
      supply <= c[0] ? MV[i] + 12'h040 : MV[i] - 12'h040;
      bus(1, SUPPLY_MONITOR_CTRL_OFS, 8'hF8 | {5'h0, i[2:0]});
      repeat (6) @(posedge clk_i);
      chk("level", MV[i], mv);
      chk("code", {9'h000, i[2:0]}, {9'h000, thr});
      chk("enable", 12'h001, {11'h000, en});
      rd(SUPPLY_MONITOR_CTRL_OFS, {2'h0, !c[0], 2'h2, i[2:0]});
    end
    sel <= 4'h0;
    bus(1, SUPPLY_MONITOR_CTRL_OFS, 8'h00);
    sel <= 4'h1;
    rd(SUPPLY_MONITOR_CTRL_OFS, {2'h0, !c[0], 5'h17});
    supply <= 12'hFFF;
    repeat (6) @(posedge clk_i);
    bus(1, IRQ_STATUS_OFS, 8'h00);
    pulse_svc();
    w0 = wakes;
    n = 0;
    supply <= 12'h800;
    while (ireq !== 1'b1 && n < 40) begin @(posedge clk_i); n++; end
    chk("delay", 12'h001, {11'h0, n > DLY + 1 && n < 40});
    repeat (2) @(posedge clk_i);
    chk("shared", 12'h001, {11'h0, sreq});
    chk("wake", 12'(w0 + 1), 12'(wakes));
    pulse_svc();
    rd(IRQ_STATUS_OFS, 8'h01);
    bus(1, IRQ_STATUS_OFS, 8'h00);
    rd(IRQ_STATUS_OFS, 8'h00);
    supply <= 12'hFFF;
    repeat (6) @(posedge clk_i);
    bus(1, IRQ_STATUS_OFS, 8'h01);
    repeat (3) @(posedge clk_i);
    w0 = wakes;
    supply <= 12'h800;
    repeat (20) @(posedge clk_i);
    chk("wake", 12'(w0), 12'(wakes));
    sleep <= 1;
    repeat (6) @(posedge clk_i);
    chk("enable", 12'h000, {11'h000, en});
    rd(SUPPLY_MONITOR_CTRL_OFS, 8'h17);
    sleep <= 0;
    results();
  end
endmodule
